/* File: inc/dsd_pkg.sv */
// shared constants and types for the data-space decoder
package dsd_pkg;
  // data-space map
  localparam logic [15:0] DSD_GPR_BASE = 16'h0000;
  localparam logic [15:0] DSD_IO_BASE = 16'h0020;
  localparam logic [15:0] DSD_EXT_BASE = 16'h0060;
  localparam logic [15:0] DSD_SRAM_BASE = 16'h0100;
  localparam int DSD_SRAM_SMALL = 512;
  localparam int DSD_SRAM_LARGE = 1024;
  localparam int DSD_SRAM_AW = 10;
  localparam int DSD_EE_BYTES = 512;
  localparam int DSD_EE_AW = 9;
  // pointer pairs in the working registers, low byte index
  localparam logic [4:0] DSD_PTR_X_LO = 5'h1A;
  localparam logic [4:0] DSD_PTR_Y_LO = 5'h1C;
  localparam logic [4:0] DSD_PTR_Z_LO = 5'h1E;
  localparam logic [4:0] DSD_PTR_HI_OFS = 5'h01;
  localparam logic [15:0] DSD_PTR_STEP = 16'h0001;
  // eeprom access registers inside standard i/o
  localparam logic [15:0] DSD_EE_CTRL_ADDR = 16'h003F;
  localparam logic [15:0] DSD_EE_DATA_ADDR = 16'h0040;
  localparam logic [15:0] DSD_EE_ADRL_ADDR = 16'h0041;
  localparam logic [15:0] DSD_EE_ADRH_ADDR = 16'h0042;
  localparam int DSD_EE_RD_BIT = 0;
  localparam int DSD_EE_WR_BIT = 1;
  localparam int DSD_EE_MWE_BIT = 2;
  // stall lengths and arming window, in cycles
  localparam logic [2:0] DSD_EE_RD_STALL = 3'h4;
  localparam logic [2:0] DSD_EE_WR_STALL = 3'h2;
  localparam logic [2:0] DSD_EE_MWE_WIN = 3'h4;
  // self-timed eeprom write
  localparam int DSD_CLK_PERIOD_NS = 25;
  localparam int DSD_EE_WR_TIME_NS = 100000;
  localparam int DSD_EE_CNT_W = 12;
  localparam logic [11:0] DSD_EE_WR_CYC = 12'(DSD_EE_WR_TIME_NS / DSD_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    DSD_MODE_DIRECT = 3'h0,
    DSD_MODE_DISP = 3'h1,
    DSD_MODE_IND = 3'h2,
    DSD_MODE_PREDEC = 3'h3,
    DSD_MODE_POSTINC = 3'h4
  } dsd_mode_t;

  typedef enum logic [1:0] {
    DSD_PTR_X = 2'h0,
    DSD_PTR_Y = 2'h1,
    DSD_PTR_Z = 2'h2
  } dsd_ptr_t;

  typedef enum logic [2:0] {
    DSD_REG_NONE = 3'h0,
    DSD_REG_GPR = 3'h1,
    DSD_REG_IO = 3'h2,
    DSD_REG_EXT = 3'h3,
    DSD_REG_SRAM = 3'h4
  } dsd_region_t;

  typedef enum logic [3:0] {
    DSD_ST_IDLE = 4'b0001,
    DSD_ST_SRAM2 = 4'b0010,
    DSD_ST_IOW = 4'b0100,
    DSD_ST_STALL = 4'b1000
  } dsd_state_t;

  typedef struct packed {
    dsd_mode_t mode;
    dsd_ptr_t ptr;
    logic [5:0] disp;
    logic short_io;
    logic [5:0] io_idx;
    logic [15:0] addr;
    logic we;
    logic [7:0] wdata;
  } dsd_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } dsd_io_t;

  typedef struct packed {
    dsd_state_t st;
    logic [31:0][7:0] gpr;
    logic [7:0] rdata;
    logic ack;
    logic bad;
    logic stall;
    dsd_region_t region;
    dsd_io_t io;
    logic [DSD_SRAM_AW-1:0] sram_idx;
    logic [2:0] stall_cnt;
    logic [DSD_EE_AW-1:0] ee_addr;
    logic [7:0] ee_data;
    logic ee_mwe;
    logic [2:0] mwe_cnt;
    logic ee_busy;
    logic [DSD_EE_CNT_W-1:0] wr_cnt;
  } dsd_core_t;
endpackage

/* File: src/dsd_addr_decode.sv */
// region decode of a data-space address
`timescale 1ns/1ps
module dsd_addr_decode
  import dsd_pkg::*;
#(
  parameter logic [15:0] P_SRAM_TOP = 16'h04FF
) (
  input wire logic [15:0] i_addr, // effective address
  output dsd_region_t o_region // decoded region
);
  always_comb begin
    if (i_addr < DSD_IO_BASE) begin
      o_region = DSD_REG_GPR;
    end else if (i_addr < DSD_EXT_BASE) begin
      o_region = DSD_REG_IO;
    end else if (i_addr < DSD_SRAM_BASE) begin
      o_region = DSD_REG_EXT;
    end else if (i_addr <= P_SRAM_TOP) begin
      o_region = DSD_REG_SRAM;
    end else begin
      o_region = DSD_REG_NONE;
    end
  end
endmodule

/* File: src/dsd_byte_mem.sv */
// flip-flop byte store, one write port, one read port
`timescale 1ns/1ps
module dsd_byte_mem
  import dsd_pkg::*;
#(
  parameter int P_DEPTH = 512,
  parameter int P_AW = 9
) (
  input wire logic i_core_clk, // clock
  input wire logic i_reset_n, // async reset, low
  input wire logic i_we, // write strobe
  input wire logic [P_AW-1:0] i_waddr, // write index
  input wire logic [7:0] i_wdata, // write byte
  input wire logic [P_AW-1:0] i_raddr, // read index
  output logic [7:0] o_rdata // read byte, combinational
);
  logic [P_DEPTH-1:0][7:0] mem_r;
  logic [P_DEPTH-1:0][7:0] mem_nxt;

  always_comb begin
    mem_nxt = mem_r;
    if (i_we && (int'(i_waddr) < P_DEPTH)) begin
      mem_nxt[i_waddr] = i_wdata;
    end
    // out-of-range index reads zero rather than x
    o_rdata = (int'(i_raddr) < P_DEPTH) ? mem_r[i_raddr] : 8'h00;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end
endmodule

/* File: src/dsd_data_space.sv */
// data-space decoder, access timing and eeprom access unit
`timescale 1ns/1ps
// What this block does
// RULE_01: lowest 32 addresses hit working registers
// RULE_02: next 64 addresses hit standard i/o
// RULE_03: next 160 addresses hit extended i/o
// RULE_04: addresses above extended i/o hit sram
// RULE_05: short i/o reaches only 64 locations
// RULE_06: core uses loads/stores for extended i/o
// RULE_07: direct addressing reaches whole data space
// RULE_08: six top working registers are pointers
// RULE_09: displacement adds up to 63 to pointer
// RULE_10: pre-decrement before, post-increment after access
// RULE_11: all regions reachable in all five modes
// RULE_12: sram access takes two clock cycles
// RULE_13: 512-byte eeprom, byte-wide separate space
// RULE_14: eeprom registers live in i/o space
// RULE_15: self-timed eeprom write with pollable busy
// RULE_16: software arms master enable before writing
// RULE_17: eeprom read stalls core four cycles
// RULE_18: eeprom write stalls core two cycles
// RULE_19: sram size parameter sets top address
module dsd_data_space
  import dsd_pkg::*;
#(
  parameter int P_SRAM_BYTES = DSD_SRAM_LARGE
) (
  input wire logic i_core_clk, // processor clock
  input wire logic i_reset_n, // async reset, low
  input wire logic i_req, // access request, taken when not stalled
  input wire dsd_req_t i_acc, // access descriptor
  input wire logic [7:0] i_io_rdata, // read data from i/o peripherals
  output logic o_ack, // access done, one-cycle pulse
  output logic [7:0] o_rdata, // read data, valid with o_ack
  output logic o_bad_addr, // unmapped address, with o_ack
  output dsd_region_t o_region, // region of last access
  output logic o_stall, // core must hold off
  output dsd_io_t o_io, // i/o peripheral strobe bundle
  output logic o_ee_busy // eeprom write in progress
);
  // RULE_19: top follows size
  localparam logic [15:0] SRAM_TOP = 16'(int'(DSD_SRAM_BASE) + P_SRAM_BYTES - 1);

  dsd_core_t s_r;
  dsd_core_t s_nxt;
  dsd_region_t region;
  logic [4:0] ptr_lo;
  logic [4:0] ptr_hi;
  logic [15:0] ptr_val;
  logic [15:0] ptr_new;
  logic ptr_upd;
  logic [15:0] ea;
  logic [15:0] sram_ofs;
  logic sram_we;
  logic [7:0] sram_rdata;
  logic ee_we;
  logic [7:0] ee_rdata;
  logic ee_reg;

  dsd_addr_decode #(
    .P_SRAM_TOP(SRAM_TOP)
  ) u_dec (
    .i_addr(ea),
    .o_region(region)
  );

  // RULE_12: sram storage
  dsd_byte_mem #(
    .P_DEPTH(P_SRAM_BYTES),
    .P_AW(DSD_SRAM_AW)
  ) u_sram (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_we(sram_we),
    .i_waddr(sram_ofs[DSD_SRAM_AW-1:0]),
    .i_wdata(i_acc.wdata),
    .i_raddr(s_r.sram_idx),
    .o_rdata(sram_rdata)
  );

  // RULE_13: eeprom storage
  dsd_byte_mem #(
    .P_DEPTH(DSD_EE_BYTES),
    .P_AW(DSD_EE_AW)
  ) u_ee (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_we(ee_we),
    .i_waddr(s_r.ee_addr),
    .i_wdata(s_r.ee_data),
    .i_raddr(s_r.ee_addr),
    .o_rdata(ee_rdata)
  );

  // effective address generation
  always_comb begin
    // RULE_08: pointer pair select
    case (i_acc.ptr)
      DSD_PTR_X: begin
        ptr_lo = DSD_PTR_X_LO;
      end
      DSD_PTR_Y: begin
        ptr_lo = DSD_PTR_Y_LO;
      end
      default: begin
        ptr_lo = DSD_PTR_Z_LO;
      end
    endcase
    ptr_hi = 5'(ptr_lo + DSD_PTR_HI_OFS);
    ptr_val = {s_r.gpr[ptr_hi], s_r.gpr[ptr_lo]};
    ptr_new = ptr_val;
    ptr_upd = 1'b0;
    // RULE_11: five modes, any region
    case (i_acc.mode)
      // RULE_07: direct reaches everything
      DSD_MODE_DIRECT: begin
        ea = i_acc.addr;
      end
      // RULE_09: up to 63 on y or z
      DSD_MODE_DISP: begin
        // x has no displacement form, so it acts as plain indirect
        if (i_acc.ptr == DSD_PTR_X) begin
          ea = ptr_val;
        end else begin
          ea = 16'(ptr_val + {10'h000, i_acc.disp});
        end
      end
      // RULE_10: decrement first
      DSD_MODE_PREDEC: begin
        ptr_new = 16'(ptr_val - DSD_PTR_STEP);
        ptr_upd = 1'b1;
        ea = ptr_new;
      end
      // RULE_10: increment after
      DSD_MODE_POSTINC: begin
        ptr_new = 16'(ptr_val + DSD_PTR_STEP);
        ptr_upd = 1'b1;
        ea = ptr_val;
      end
      default: begin
        ea = ptr_val;
      end
    endcase
    // RULE_05: opcode field only spans standard i/o
    if (i_acc.short_io) begin
      ea = 16'(DSD_IO_BASE + {10'h000, i_acc.io_idx});
      ptr_upd = 1'b0;
    end
    sram_ofs = 16'(ea - DSD_SRAM_BASE);
    // RULE_14: eeprom registers intercepted
    ee_reg = (ea == DSD_EE_CTRL_ADDR) || (ea == DSD_EE_DATA_ADDR) ||
             (ea == DSD_EE_ADRL_ADDR) || (ea == DSD_EE_ADRH_ADDR);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.bad = 1'b0;
    s_nxt.io.we = 1'b0;
    s_nxt.io.re = 1'b0;
    sram_we = 1'b0;
    ee_we = 1'b0;

    // RULE_16: arming lapses after a short window
    if (s_r.mwe_cnt != 3'h0) begin
      s_nxt.mwe_cnt = 3'(s_r.mwe_cnt - 3'h1);
      if (s_r.mwe_cnt == 3'h1) begin
        s_nxt.ee_mwe = 1'b0;
      end
    end

    // RULE_15: self-timed write countdown
    if (s_r.ee_busy) begin
      s_nxt.wr_cnt = 12'(s_r.wr_cnt - 12'h001);
      if (s_r.wr_cnt == 12'h001) begin
        s_nxt.ee_busy = 1'b0;
      end
    end

    case (s_r.st)
      DSD_ST_IDLE: begin
        if (i_req) begin
          s_nxt.region = region;
          // RULE_10: pointer write-back
          if (ptr_upd) begin
            s_nxt.gpr[ptr_lo] = ptr_new[7:0];
            s_nxt.gpr[ptr_hi] = ptr_new[15:8];
          end
          case (region)
            // RULE_01: working registers
            DSD_REG_GPR: begin
              if (i_acc.we) begin
                s_nxt.gpr[ea[4:0]] = i_acc.wdata;
              end
              s_nxt.rdata = s_r.gpr[ea[4:0]];
              s_nxt.ack = 1'b1;
            end
            // RULE_02: standard i/o
            // RULE_03: extended i/o
            DSD_REG_IO, DSD_REG_EXT: begin
              if (ee_reg) begin
                s_nxt.ack = 1'b1;
                if (ea == DSD_EE_ADRL_ADDR) begin
                  s_nxt.rdata = s_r.ee_addr[7:0];
                  if (i_acc.we) begin
                    s_nxt.ee_addr[7:0] = i_acc.wdata;
                  end
                end else if (ea == DSD_EE_ADRH_ADDR) begin
                  s_nxt.rdata = {7'h00, s_r.ee_addr[DSD_EE_AW-1]};
                  if (i_acc.we) begin
                    s_nxt.ee_addr[DSD_EE_AW-1] = i_acc.wdata[0];
                  end
                end else if (ea == DSD_EE_DATA_ADDR) begin
                  s_nxt.rdata = s_r.ee_data;
                  if (i_acc.we) begin
                    s_nxt.ee_data = i_acc.wdata;
                  end
                end else begin
                  // RULE_15: busy readable for polling
                  s_nxt.rdata = 8'h00;
                  s_nxt.rdata[DSD_EE_WR_BIT] = s_r.ee_busy;
                  s_nxt.rdata[DSD_EE_MWE_BIT] = s_r.ee_mwe;
                  if (i_acc.we) begin
                    if (i_acc.wdata[DSD_EE_RD_BIT] && !s_r.ee_busy) begin
                      // RULE_17: read stalls four
                      s_nxt.ee_data = ee_rdata;
                      s_nxt.ack = 1'b0;
                      s_nxt.stall = 1'b1;
                      s_nxt.stall_cnt = DSD_EE_RD_STALL;
                      s_nxt.st = DSD_ST_STALL;
                    end else if (i_acc.wdata[DSD_EE_WR_BIT] && s_r.ee_mwe && !s_r.ee_busy) begin
                      // RULE_16: write only when armed
                      ee_we = 1'b1;
                      s_nxt.ee_mwe = 1'b0;
                      s_nxt.mwe_cnt = 3'h0;
                      s_nxt.ee_busy = 1'b1;
                      s_nxt.wr_cnt = DSD_EE_WR_CYC;
                      // RULE_18: write stalls two
                      s_nxt.ack = 1'b0;
                      s_nxt.stall = 1'b1;
                      s_nxt.stall_cnt = DSD_EE_WR_STALL;
                      s_nxt.st = DSD_ST_STALL;
                    end else if (i_acc.wdata[DSD_EE_MWE_BIT]) begin
                      s_nxt.ee_mwe = 1'b1;
                      s_nxt.mwe_cnt = DSD_EE_MWE_WIN;
                    end
                  end
                end
              end else begin
                s_nxt.io.addr = ea[7:0];
                s_nxt.io.wdata = i_acc.wdata;
                s_nxt.io.we = i_acc.we;
                s_nxt.io.re = !i_acc.we;
                s_nxt.stall = 1'b1;
                s_nxt.st = DSD_ST_IOW;
              end
            end
            // RULE_04: internal sram
            DSD_REG_SRAM: begin
              // RULE_12: write lands now, answer next cycle
              sram_we = i_acc.we;
              s_nxt.sram_idx = sram_ofs[DSD_SRAM_AW-1:0];
              s_nxt.stall = 1'b1;
              s_nxt.st = DSD_ST_SRAM2;
            end
            default: begin
              // unmapped: answer at once so the core never hangs
              s_nxt.rdata = 8'h00;
              s_nxt.bad = 1'b1;
              s_nxt.ack = 1'b1;
            end
          endcase
        end
      end
      // RULE_12: second sram cycle
      DSD_ST_SRAM2: begin
        s_nxt.rdata = sram_rdata;
        s_nxt.ack = 1'b1;
        s_nxt.stall = 1'b0;
        s_nxt.st = DSD_ST_IDLE;
      end
      DSD_ST_IOW: begin
        s_nxt.rdata = i_io_rdata;
        s_nxt.ack = 1'b1;
        s_nxt.stall = 1'b0;
        s_nxt.st = DSD_ST_IDLE;
      end
      // RULE_17: hold core for the count
      DSD_ST_STALL: begin
        if (s_r.stall_cnt == 3'h1) begin
          s_nxt.rdata = s_r.ee_data;
          s_nxt.ack = 1'b1;
          s_nxt.stall = 1'b0;
          s_nxt.stall_cnt = 3'h0;
          s_nxt.st = DSD_ST_IDLE;
        end else begin
          s_nxt.stall_cnt = 3'(s_r.stall_cnt - 3'h1);
        end
      end
      default: begin
        s_nxt.stall = 1'b0;
        s_nxt.st = DSD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= '0;
      s_r.st <= DSD_ST_IDLE;
      s_r.region <= DSD_REG_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ack = s_r.ack;
  assign o_rdata = s_r.rdata;
  assign o_bad_addr = s_r.bad;
  assign o_region = s_r.region;
  assign o_stall = s_r.stall;
  assign o_io = s_r.io;
  assign o_ee_busy = s_r.ee_busy;
endmodule

/* File: verif/dsd_data_space_properties.sv */
// port-level checks for the data-space decoder
`timescale 1ns/1ps
module dsd_data_space_properties
  import dsd_pkg::*;
#(
  parameter int P_SRAM_BYTES = DSD_SRAM_LARGE
) (
  input wire logic i_core_clk, // clock
  input wire logic i_reset_n, // reset, low
  input wire logic i_req, // request
  input wire dsd_req_t i_acc, // descriptor
  input wire logic [7:0] i_io_rdata, // i/o data
  input wire logic o_ack, // done
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_bad_addr, // unmapped
  input wire dsd_region_t o_region, // region
  input wire logic o_stall, // stall
  input wire dsd_io_t o_io, // i/o strobes
  input wire logic o_ee_busy // eeprom busy
);
  localparam logic [15:0] TOP = 16'(32'h00FF + P_SRAM_BYTES);
  logic dir, ctl, ee_go;
  logic [2:0] arm_age_r;
  logic [12:0] busy_cnt_r;
  assign dir = i_req && !o_stall && i_acc.mode == DSD_MODE_DIRECT && !i_acc.short_io;
  assign ctl = dir && i_acc.we && i_acc.addr == DSD_EE_CTRL_ADDR;
  // only a start right after arming is safe to expect
  assign ee_go = ctl && i_acc.wdata[1:0] == 2'b10 && arm_age_r <= 3'h1 && !o_ee_busy;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arm_age_r <= 3'h7;
      busy_cnt_r <= 13'h0000;
    end else begin
      if (ctl && i_acc.wdata[2:0] == 3'b100) begin
        arm_age_r <= 3'h0;
      end else if (ctl && i_acc.wdata[1]) begin
        arm_age_r <= 3'h7;
      end else if (arm_age_r != 3'h7) begin
        arm_age_r <= arm_age_r + 3'h1;
      end
      busy_cnt_r <= o_ee_busy ? busy_cnt_r + 13'h0001 : 13'h0000;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_done;
    o_ack && !o_stall;
  endsequence
  sequence s_sram_wait;
    o_stall && o_region == DSD_REG_SRAM;
  endsequence
  a_gpr_one_cycle: assert property (dir && i_acc.addr < DSD_IO_BASE
    |-> ##1 o_ack && o_region == DSD_REG_GPR)
    else $error("gpr access slow or misdecoded");
  a_io_strobe: assert property (dir && i_acc.addr >= DSD_IO_BASE && i_acc.addr < DSD_EXT_BASE
    && (i_acc.addr < DSD_EE_CTRL_ADDR || i_acc.addr > DSD_EE_ADRH_ADDR)
    |-> ##1 o_region == DSD_REG_IO && (o_io.re || o_io.we) && o_io.addr == $past(i_acc.addr[7:0]))
    else $error("standard i/o access misrouted");
  a_ext_region: assert property (dir && i_acc.addr >= DSD_EXT_BASE && i_acc.addr < DSD_SRAM_BASE
    |-> ##1 o_region == DSD_REG_EXT)
    else $error("extended i/o misdecoded");
  a_sram_two_cycle: assert property (dir && i_acc.addr >= DSD_SRAM_BASE && i_acc.addr <= TOP
    |-> ##1 s_sram_wait ##1 s_done)
    else $error("sram access not two cycles");
  a_bad_above_top: assert property (dir && i_acc.addr > TOP && !i_acc.we
    |-> ##1 o_ack && o_bad_addr && o_rdata == 8'h00)
    else $error("address above sram not flagged");
  a_short_io_map: assert property (i_req && !o_stall && i_acc.short_io
    && (i_acc.io_idx < 6'h1F || i_acc.io_idx > 6'h22) |-> ##1 o_io.addr == 8'h20 + {2'b00, $past(i_acc.io_idx)})
    else $error("short i/o index misplaced");
  a_ee_rd_stall: assert property (ctl && i_acc.wdata[0] && !o_ee_busy |-> ##1 o_stall [*4] ##1 s_done)
    else $error("eeprom read stall wrong");
  a_ee_wr_stall: assert property (ee_go |-> ##1 o_stall && o_ee_busy ##1 o_stall ##1 s_done)
    else $error("eeprom write stall wrong");
  a_busy_bound: assert property (busy_cnt_r <= {1'b0, DSD_EE_WR_CYC})
    else $error("eeprom busy too long");
endmodule

/* File: verif/dsd_io_model.sv */
// behavioural i/o peripheral bank behind the strobe bundle
`timescale 1ns/1ps
module dsd_io_model
  import dsd_pkg::*;
(
  input wire logic i_core_clk, // clock
  input wire logic i_reset_n, // reset, low
  input wire dsd_io_t i_io, // strobes from decoder
  output logic [7:0] o_io_rdata // read data to decoder
);
  logic [7:0] regs_r [256];
  logic [7:0] junk_r;
  always_ff @(posedge i_core_clk) begin
    if (i_io.we) begin
      regs_r[i_io.addr] <= i_io.wdata;
    end
  end
  // undriven bus keeps moving so a stale sample never matches
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      junk_r <= 8'hA5;
    end else begin
      junk_r <= junk_r + 8'h3B;
    end
  end
  assign o_io_rdata = i_io.re ? regs_r[i_io.addr] : junk_r;
endmodule

/* File: verif/dsd_data_space_test.sv */
// self-checking bench for the data-space decoder
`timescale 1ns/1ps
module dsd_data_space_test
  import dsd_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_req = 1'b0;
  dsd_req_t i_acc = '0;
  dsd_req_t r;
  logic [7:0] io_rdata, o_rdata, d0;
  logic o_ack, o_bad_addr, o_stall, o_ee_busy;
  dsd_region_t o_region;
  dsd_io_t o_io;
  int failures = 0;
  int n_compared = 0;
  int n_cyc, k;
  logic [9:0] exp_q[$];
  logic [9:0] note;
  logic [7:0] dat[5];
  logic [15:0] atab[5] = '{16'h0005, 16'h0025, 16'h0080, 16'h0100, 16'h02FF};
  dsd_region_t rtab[5] = '{DSD_REG_GPR, DSD_REG_IO, DSD_REG_EXT, DSD_REG_SRAM, DSD_REG_SRAM};

  always #12.5 i_core_clk = ~i_core_clk;

  dsd_data_space #(.P_SRAM_BYTES(DSD_SRAM_SMALL)) i_dsd_data_space (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_req(i_req), .i_acc(i_acc), .i_io_rdata(io_rdata), .o_ack(o_ack),
    .o_rdata(o_rdata), .o_bad_addr(o_bad_addr), .o_region(o_region), .o_stall(o_stall), .o_io(o_io),
    .o_ee_busy(o_ee_busy));
  dsd_io_model i_dsd_io_model (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_io(o_io),
    .o_io_rdata(io_rdata));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic dsd_req_t rq(dsd_mode_t m, dsd_ptr_t p, logic [15:0] a, logic w, logic [7:0] wd);
    return '{mode: m, ptr: p, disp: 6'h00, short_io: 1'b0, io_idx: 6'h00, addr: a, we: w, wdata: wd};
  endfunction

  // request is taken at the next edge; ack waited for under a bound
  task automatic acc(input dsd_req_t q, input logic chk, input logic [7:0] er, input logic bad);
    exp_q.push_back({chk, bad, er});
    i_req <= 1'b1;
    i_acc <= q;
    @(posedge i_core_clk);
    i_req <= 1'b0;
    n_cyc = 0;
    do begin
      @(posedge i_core_clk);
      n_cyc++;
    end while (o_ack !== 1'b1 && n_cyc < 20);
    if (o_ack !== 1'b1) begin
      failures++;
      $display("ERROR %0t: no ack", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] wd);
    acc(rq(DSD_MODE_DIRECT, DSD_PTR_X, a, 1'b1, wd), 1'b0, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] er);
    acc(rq(DSD_MODE_DIRECT, DSD_PTR_X, a, 1'b0, 8'h00), 1'b1, er, 1'b0);
  endtask
  task automatic setp(input logic [4:0] lo, input logic [15:0] v);
    wr({11'h000, lo}, v[7:0]);
    wr({11'h000, lo + DSD_PTR_HI_OFS}, v[15:8]);
  endtask

  always @(posedge i_core_clk) begin
    if (i_reset_n === 1'b1 && o_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("ERROR %0t: stray ack", $time);
      end else begin
        note = exp_q.pop_front();
        if (note[9]) begin
          check(o_rdata, note[7:0]);
        end
        check({7'h00, o_bad_addr}, {7'h00, note[8]});
      end
    end
  end

  initial begin
    void'($urandom(32'h54CE));
    repeat (3) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    @(posedge i_core_clk);
    for (k = 0; k < 5; k++) begin
      dat[k] = 8'($urandom());
      wr(atab[k], dat[k]);
      rd(atab[k], dat[k]);
      check(8'(n_cyc), (k == 0) ? 8'h01 : 8'h02);
      check({5'h00, o_region}, {5'h00, rtab[k]});
    end
    // short form must ignore the direct address field
    r = rq(DSD_MODE_DIRECT, DSD_PTR_X, 16'hFFFF, 1'b1, 8'h3C);
    r.short_io = 1'b1;
    r.io_idx = 6'h05;
    acc(r, 1'b0, 8'h00, 1'b0);
    rd(16'h0025, 8'h3C);
    acc(rq(DSD_MODE_DIRECT, DSD_PTR_X, 16'h0300, 1'b0, 8'h00), 1'b1, 8'h00, 1'b1);
    setp(DSD_PTR_Y_LO, 16'h0150);
    r = rq(DSD_MODE_DISP, DSD_PTR_Y, 16'h0000, 1'b1, 8'h5E);
    r.disp = 6'h3F;
    acc(r, 1'b0, 8'h00, 1'b0);
    rd(16'h018F, 8'h5E);
    setp(DSD_PTR_Z_LO, 16'h0200);
    acc(rq(DSD_MODE_PREDEC, DSD_PTR_Z, 16'h0000, 1'b1, 8'hC3), 1'b0, 8'h00, 1'b0);
    rd(16'h01FF, 8'hC3);
    rd(16'h001E, 8'hFF);
    rd(16'h001F, 8'h01);
    setp(DSD_PTR_X_LO, 16'h0025);
    acc(rq(DSD_MODE_POSTINC, DSD_PTR_X, 16'h0000, 1'b0, 8'h00), 1'b1, 8'h3C, 1'b0);
    rd(16'h001A, 8'h26);
    setp(DSD_PTR_Y_LO, 16'h0005);
    acc(rq(DSD_MODE_IND, DSD_PTR_Y, 16'h0000, 1'b0, 8'h00), 1'b1, dat[0], 1'b0);
    wr(DSD_EE_ADRL_ADDR, 8'h34);
    wr(DSD_EE_ADRH_ADDR, 8'h01);
    d0 = 8'($urandom());
    wr(DSD_EE_DATA_ADDR, d0);
    wr(DSD_EE_CTRL_ADDR, 8'h02);
    check({7'h00, o_ee_busy}, 8'h00);
    wr(DSD_EE_CTRL_ADDR, 8'h04);
    wr(DSD_EE_CTRL_ADDR, 8'h02);
    check(8'(n_cyc), 8'h03);
    check({7'h00, o_ee_busy}, 8'h01);
    k = 0;
    do begin
      acc(rq(DSD_MODE_DIRECT, DSD_PTR_X, DSD_EE_CTRL_ADDR, 1'b0, 8'h00), 1'b0, 8'h00, 1'b0);
      k++;
    end while (o_rdata[DSD_EE_WR_BIT] !== 1'b0 && k < 5000);
    // each poll costs two cycles, so the count is half the write time
    check(8'(k >= int'(DSD_EE_WR_CYC) / 2 - 1 && k <= int'(DSD_EE_WR_CYC) / 2 + 1), 8'h01);
    if (k >= 5000) begin
      close_out();
    end
    wr(DSD_EE_DATA_ADDR, 8'h00);
    acc(rq(DSD_MODE_DIRECT, DSD_PTR_X, DSD_EE_CTRL_ADDR, 1'b1, 8'h01), 1'b1, d0, 1'b0);
    check(8'(n_cyc), 8'h05);
    rd(DSD_EE_DATA_ADDR, d0);
    wr(DSD_EE_ADRH_ADDR, 8'h00);
    acc(rq(DSD_MODE_DIRECT, DSD_PTR_X, DSD_EE_CTRL_ADDR, 1'b1, 8'h01), 1'b1, 8'h00, 1'b0);
    close_out();
  end
endmodule

bind dsd_data_space dsd_data_space_properties #(.P_SRAM_BYTES(P_SRAM_BYTES)) i_dsd_data_space_properties (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_req(i_req), .i_acc(i_acc), .i_io_rdata(i_io_rdata),
  .o_ack(o_ack), .o_rdata(o_rdata), .o_bad_addr(o_bad_addr), .o_region(o_region), .o_stall(o_stall),
  .o_io(o_io), .o_ee_busy(o_ee_busy));
